// >>> inc/sdrpf_defs.vh
// Constants for the memory-side pin function block
`ifndef SDRPF_DEFS_VH
`define SDRPF_DEFS_VH
`define SDRPF_CLK_MHZ 100
`define SDRPF_CRC_ALERT_NS 100
`define SDRPF_CRC_ALERT_CYC ((`SDRPF_CRC_ALERT_NS*`SDRPF_CLK_MHZ)/1000)
`define SDRPF_PAR_RECOV_NS 500
`define SDRPF_PAR_RECOV_CYC ((`SDRPF_PAR_RECOV_NS*`SDRPF_CLK_MHZ)/1000)
`define SDRPF_MR5_DM_BIT 10
`define SDRPF_MR5_WDBI_BIT 11
`define SDRPF_MR5_RDBI_BIT 12
`define SDRPF_MR5_PAR_BIT 0
`define SDRPF_MR4_VREF_BIT 4
`define SDRPF_MR1_TDQS_BIT 11
`define SDRPF_MR2_CRC_BIT 12
`define SDRPF_ADDR_W 17
`define SDRPF_BEATS 8
`define SDRPF_CMD_RD 3'h5
`define SDRPF_CMD_WR 3'h4
`define SDRPF_CMD_PRE 3'h2
`endif

// >>> src/sdrpf_buf2.v
// Two-entry valid/ready buffer
`timescale 1ns/1ns
module sdrpf_buf2 #(
  parameter W = 16
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_valid,
  output wire o_ready,
  input wire [W-1:0] i_data,
  output wire o_valid,
  input wire i_ready,
  output wire [W-1:0] o_data
);
  reg [W-1:0] mem_r [0:1];
  reg wp_r;
  reg rp_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;

  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data = mem_r[rp_r];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // Pointers and fill count
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      if (push & ~pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 2'h1;
    end
  end

  // Storage has no reset; read only when valid
  always @(posedge i_clk) begin
    if (push)
      mem_r[wp_r] <= i_data;
  end
endmodule

// >>> src/sdrpf_sync.v
// Two-flop synchroniser for asynchronous input levels
`timescale 1ns/1ns
module sdrpf_sync #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [W-1:0] i_d,
  output reg [W-1:0] o_q
);
  reg [W-1:0] meta_r;

  // First stage feeds only the second
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_r <= {W{1'b0}};
      o_q <= {W{1'b0}};
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule

// >>> src/sdrpf_top.v
// Memory-side pin function logic: commands, parity, mask, inversion, alert
//
// Notes on behaviour
// - ODT registered high turns on termination on data, strobe, mask lines.
// - In x16 mode termination covers all bits, both strobes, both masks.
// - Termination disabled by mode registers makes ODT ignored completely.
// - With parity enabled, parity covers ACT, RAS/CAS/WE, BG, BA, A.
// - ACT low makes RAS/CAS/WE row bits 16..14; else command bits.
// - Reset pin is asynchronous, active low, held high in operation; code synchronises it and only gates command capture.
// - With CRC enabled, a CRC tail follows the last beat of bursts.
// - Mode register 4 bit 4 lets data bits 0..3 expose reference level.
// - Write beats sampled with mask low are discarded; both strobe edges.
// - Mode register 5 bits 10..12 choose mask or inversion use.
// - x8 parts: mode register 1 bit 11 picks mask or termination strobe.
// - Inversion indicator low inverts the byte on writes and reads.
// - Memory drives strobe on reads edge aligned; controller on writes.
// - x16 lower strobe times bits 7..0, upper 15..8; else one strobe.
// - Only differential strobes are used; single ended is unsupported.
// - Write CRC error pulls alert low a fixed interval, then releases.
// - Parity error holds alert low until internal recovery finishes.
// - In connectivity test mode the alert pin acts as an input.
// - Temperature event output follows the sensor's critical flag.
// - Commands sampled while chip select is high are ignored.
// - Command and address sampled on rising edge of the true clock.
// - A10 gives auto precharge on read/write, all banks on precharge.
// - A12 low chops the burst on read/write; high keeps full burst.
////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "sdrpf_defs.vh"
module sdrpf_top #(
  parameter CRC_CYC = `SDRPF_CRC_ALERT_CYC,
  parameter REC_CYC = `SDRPF_PAR_RECOV_CYC
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_reset_n,
  input wire i_ck_t,
  input wire i_ck_c,
  input wire i_cs_n,
  input wire i_act_n,
  input wire i_ras_n_a16,
  input wire i_cas_n_a15,
  input wire i_we_n_a14,
  input wire [1:0] i_bg,
  input wire [1:0] i_ba,
  input wire [13:0] i_a_lo,
  input wire i_parity,
  input wire i_odt,
  input wire i_x16,
  input wire i_rtt_en,
  input wire [15:0] i_mr1,
  input wire [15:0] i_mr2,
  input wire [15:0] i_mr4,
  input wire [15:0] i_mr5,
  input wire i_conn_test,
  input wire i_temp_crit,
  input wire i_has_sensor,
  input wire [15:0] i_wdata,
  input wire [1:0] i_wmask_n,
  input wire [1:0] i_wdbi_n,
  input wire i_wvalid,
  input wire i_wcrc_err,
  input wire [15:0] i_rdata,
  input wire i_rvalid,
  input wire [3:0] i_vref_probe,
  output wire o_wready,
  output wire [15:0] o_store_data,
  output wire [1:0] o_store_en,
  output wire o_store_valid,
  input wire i_store_ready,
  output reg [15:0] o_dq_out,
  output reg [15:0] o_dq_oe,
  output reg [1:0] o_rdbi_n,
  output reg [1:0] o_dqs_oe,
  output reg o_dqs_t,
  output reg o_dqs_c,
  output reg [1:0] o_rtt_on_dq,
  output reg [1:0] o_rtt_on_dqs,
  output reg [1:0] o_rtt_on_dm,
  output reg o_rtt_on_tdqs,
  output reg o_tdqs_mode,
  output reg o_dm_en,
  output reg o_wdbi_en,
  output reg o_rdbi_en,
  output reg o_cmd_valid,
  output reg [2:0] o_cmd,
  output reg o_act_valid,
  output reg [16:0] o_row,
  output reg [1:0] o_bg,
  output reg [1:0] o_ba,
  output reg [13:0] o_col,
  output reg o_auto_pre,
  output reg o_pre_all,
  output reg o_burst_chop,
  output reg o_crc_tail,
  output reg o_par_err,
  output reg o_alert_out,
  output reg o_alert_oe,
  input wire i_alert_in,
  output reg o_alert_seen_n,
  output reg o_event_n
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CRC = 2'h1;
  localparam ST_PAR = 2'h2;

  // Inversion helper used on the write path only
  function [7:0] dbi_apply;
    input [7:0] d;
    input dbi_n;
    begin
      dbi_apply = dbi_n ? d : ~d;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Synchronise the command, clock, reset, ODT, alert and temperature inputs
  wire [30:0] cmd_raw;
  wire [30:0] cmd_s;
  wire ck_t_s;
  wire ck_c_s;
  wire rst_n_s;
  wire odt_s;
  wire alert_in_s;
  wire temp_s;
  assign cmd_raw = {i_cs_n, i_act_n, i_ras_n_a16, i_cas_n_a15,
    i_we_n_a14, i_bg, i_ba, i_a_lo, i_parity, 7'h00};

  sdrpf_sync #(.W(31)) u_sync_cmd (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_d(cmd_raw), .o_q(cmd_s));
  sdrpf_sync #(.W(6)) u_sync_misc (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_d({i_ck_t, i_ck_c, i_reset_n, i_odt, i_alert_in, i_temp_crit}),
    .o_q({ck_t_s, ck_c_s, rst_n_s, odt_s, alert_in_s, temp_s}));

  wire s_cs_n = cmd_s[30];
  wire s_act_n = cmd_s[29];
  wire s_ras = cmd_s[28];
  wire s_cas = cmd_s[27];
  wire s_we = cmd_s[26];
  wire [1:0] s_bg = cmd_s[25:24];
  wire [1:0] s_ba = cmd_s[23:22];
  wire [13:0] s_a = cmd_s[21:8];
  wire s_par = cmd_s[7];

  ////////////////////////////////////////////////////////////////////
  // Clock edge detect: true rising with complement falling
  reg ck_t_d_r;
  reg ck_c_d_r;
  wire ck_rise;
  assign ck_rise = ck_t_s & ~ck_t_d_r & ~ck_c_s & ck_c_d_r;

  // Pin reset acts as soon as it is seen low
  wire core_rst;
  assign core_rst = ~rst_n_s;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ck_t_d_r <= 1'b0;
      ck_c_d_r <= 1'b1;
    end else begin
      ck_t_d_r <= ck_t_s;
      ck_c_d_r <= ck_c_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Command capture and decode
  wire take;
  wire par_calc;
  wire par_on;
  assign take = ck_rise & ~s_cs_n & ~core_rst;
  assign par_on = i_mr5[`SDRPF_MR5_PAR_BIT];
  // Even parity over the full command/address word
  assign par_calc = ^{s_act_n, s_ras, s_cas, s_we, s_bg, s_ba,
    s_a, s_par};

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cmd_valid <= 1'b0;
      o_cmd <= 3'h7;
      o_act_valid <= 1'b0;
      o_row <= 17'h00000;
      o_bg <= 2'h0;
      o_ba <= 2'h0;
      o_col <= 14'h0000;
      o_auto_pre <= 1'b0;
      o_pre_all <= 1'b0;
      o_burst_chop <= 1'b0;
      o_par_err <= 1'b0;
    end else begin
      o_cmd_valid <= 1'b0;
      o_act_valid <= 1'b0;
      o_par_err <= 1'b0;
      // Parity check relies on parity arriving with its command
      if (take && par_on && par_calc) begin
        o_par_err <= 1'b1;
      end else if (take) begin
        o_bg <= s_bg;
        o_ba <= s_ba;
        if (!s_act_n) begin
          o_act_valid <= 1'b1;
          o_row <= {s_ras, s_cas, s_we, s_a};
        end else begin
          o_cmd_valid <= 1'b1;
          o_cmd <= {s_ras, s_cas, s_we};
          o_col <= s_a;
          o_auto_pre <= 1'b0;
          o_pre_all <= 1'b0;
          o_burst_chop <= 1'b0;
          if ({s_ras, s_cas, s_we} == `SDRPF_CMD_RD ||
              {s_ras, s_cas, s_we} == `SDRPF_CMD_WR) begin
            o_auto_pre <= s_a[10];
            o_burst_chop <= ~s_a[12];
          end
          if ({s_ras, s_cas, s_we} == `SDRPF_CMD_PRE)
            o_pre_all <= s_a[10];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin mode selection and termination
  wire tdqs_sel;
  assign tdqs_sel = ~i_x16 & i_mr1[`SDRPF_MR1_TDQS_BIT];

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tdqs_mode <= 1'b0;
      o_dm_en <= 1'b0;
      o_wdbi_en <= 1'b0;
      o_rdbi_en <= 1'b0;
      o_rtt_on_dq <= 2'h0;
      o_rtt_on_dqs <= 2'h0;
      o_rtt_on_dm <= 2'h0;
      o_rtt_on_tdqs <= 1'b0;
    end else begin
      o_tdqs_mode <= tdqs_sel;
      o_dm_en <= i_mr5[`SDRPF_MR5_DM_BIT] & ~tdqs_sel;
      o_wdbi_en <= i_mr5[`SDRPF_MR5_WDBI_BIT] & ~tdqs_sel;
      o_rdbi_en <= i_mr5[`SDRPF_MR5_RDBI_BIT] & ~tdqs_sel;
      if (i_rtt_en && odt_s && ck_rise) begin
        o_rtt_on_dq <= {i_x16, 1'b1};
        o_rtt_on_dqs <= {i_x16, 1'b1};
        o_rtt_on_dm <= {i_x16, 1'b1};
        o_rtt_on_tdqs <= tdqs_sel;
      end else if (!i_rtt_en || (ck_rise && !odt_s)) begin
        o_rtt_on_dq <= 2'h0;
        o_rtt_on_dqs <= 2'h0;
        o_rtt_on_dm <= 2'h0;
        o_rtt_on_tdqs <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write path: inversion, mask, then buffer to array
  wire [15:0] wd_inv;
  wire [1:0] wen;
  assign wd_inv[7:0] = o_wdbi_en ? dbi_apply(i_wdata[7:0], i_wdbi_n[0])
    : i_wdata[7:0];
  assign wd_inv[15:8] = o_wdbi_en ? dbi_apply(i_wdata[15:8], i_wdbi_n[1])
    : i_wdata[15:8];
  // Masked lanes dropped; beats arrive per strobe edge
  assign wen = o_dm_en ? i_wmask_n : 2'h3;

  wire [17:0] buf_out;
  sdrpf_buf2 #(.W(18)) u_wbuf (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_valid(i_wvalid & (wen != 2'h0)), .o_ready(o_wready),
    .i_data({wen, wd_inv}),
    .o_valid(o_store_valid), .i_ready(i_store_ready),
    .o_data(buf_out));
  assign o_store_data = buf_out[15:0];
  assign o_store_en = buf_out[17:16];

  ////////////////////////////////////////////////////////////////////
  // Read path: drive data and strobes, optional inversion, CRC tail
  reg [3:0] beat_r;
  wire crc_on;
  wire vref_on;
  assign crc_on = i_mr2[`SDRPF_MR2_CRC_BIT];
  assign vref_on = i_mr4[`SDRPF_MR4_VREF_BIT];

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dq_out <= 16'h0000;
      o_dq_oe <= 16'h0000;
      o_rdbi_n <= 2'h3;
      o_dqs_oe <= 2'h0;
      o_dqs_t <= 1'b0;
      o_dqs_c <= 1'b1;
      o_crc_tail <= 1'b0;
      beat_r <= 4'h0;
    end else begin
      o_crc_tail <= 1'b0;
      if (i_rvalid) begin
        // Invert a byte when its upper four bits are all low
        o_rdbi_n[0] <= ~(o_rdbi_en && (i_rdata[7:0] < 8'h10));
        o_rdbi_n[1] <= ~(o_rdbi_en && (i_rdata[15:8] < 8'h10));
        o_dq_out[7:0] <= (o_rdbi_en && i_rdata[7:0] < 8'h10) ?
          ~i_rdata[7:0] : i_rdata[7:0];
        o_dq_out[15:8] <= (o_rdbi_en && i_rdata[15:8] < 8'h10) ?
          ~i_rdata[15:8] : i_rdata[15:8];
        o_dq_oe <= i_x16 ? 16'hFFFF : 16'h00FF;
        o_dqs_oe <= {i_x16, 1'b1};
        o_dqs_t <= ~o_dqs_t;
        o_dqs_c <= o_dqs_t;
        if (beat_r == `SDRPF_BEATS - 1) begin
          beat_r <= 4'h0;
          o_crc_tail <= crc_on;
        end else begin
          beat_r <= beat_r + 4'h1;
        end
      end else if (vref_on) begin
        o_dq_out <= {12'h000, i_vref_probe};
        o_dq_oe <= 16'h000F;
        o_dqs_oe <= 2'h0;
      end else begin
        o_dq_oe <= 16'h0000; // Release so controller can write
        o_dqs_oe <= 2'h0;
        o_dqs_t <= 1'b0;
        o_dqs_c <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Alert sequencer; parity error outranks CRC pulse
  reg [1:0] st_r;
  reg [15:0] cnt_r;
  // one counter serves both lengths; st_r tells them apart
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      o_alert_out <= 1'b1;
      o_alert_oe <= 1'b0;
      o_alert_seen_n <= 1'b1;
      o_event_n <= 1'b1;
    end else begin
      o_event_n <= ~(i_has_sensor & temp_s);
      o_alert_seen_n <= i_conn_test ? alert_in_s : 1'b1;
      o_alert_oe <= ~i_conn_test;
      case (st_r)
        ST_IDLE: begin
          o_alert_out <= 1'b1;
          if (o_par_err) begin
            st_r <= ST_PAR;
            cnt_r <= REC_CYC[15:0];
            o_alert_out <= 1'b0;
          end else if (i_wcrc_err && crc_on) begin
            st_r <= ST_CRC;
            cnt_r <= CRC_CYC[15:0];
            o_alert_out <= 1'b0;
          end
        end
        ST_CRC: begin
          if (o_par_err) begin
            st_r <= ST_PAR;
            cnt_r <= REC_CYC[15:0];
          end else if (cnt_r <= 16'h0001) begin
            st_r <= ST_IDLE;
            o_alert_out <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        ST_PAR: begin
          if (cnt_r <= 16'h0001) begin
            st_r <= ST_IDLE;
            o_alert_out <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        default: begin
          st_r <= ST_IDLE;
          o_alert_out <= 1'b1;
        end
      endcase
    end
  end
endmodule

// >>> tb/sdrpf_chk.sv
// Checker for the memory-side pin block: alert, command, buffer timing
`timescale 1ns/1ns
module sdrpf_chk #(
  parameter CRC_CYC = 3,
  parameter REC_CYC = 6
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_conn_test,
  input wire i_has_sensor,
  input wire i_rtt_en,
  input wire i_store_ready,
  input wire i_wcrc_err,
  input wire [15:0] i_mr2,
  input wire [15:0] i_mr5,
  input wire o_cmd_valid,
  input wire o_act_valid,
  input wire o_par_err,
  input wire o_alert_out,
  input wire o_alert_oe,
  input wire o_store_valid,
  input wire [15:0] o_store_data,
  input wire o_crc_tail,
  input wire [1:0] o_rtt_on_dq,
  input wire o_event_n,
  input wire o_tdqs_mode,
  input wire o_rdbi_en
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  //////////////////////////////////////////////////////////////////////
  // Low-run length of alert and its cause, so both lengths are judged
  reg [7:0] low_cnt_r;
  reg par_kind_r;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      low_cnt_r <= 8'h00;
      par_kind_r <= 1'b0;
    end else begin
      low_cnt_r <= o_alert_out ? 8'h00 : low_cnt_r + 8'h01;
      if (o_par_err)
        par_kind_r <= 1'b1;
      else if (o_alert_out)
        par_kind_r <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Alert steps: a cause, then the pin pulled low
  sequence s_crc_req; i_wcrc_err && i_mr2[12] && o_alert_out; endsequence
  sequence s_alert_low; !o_alert_out; endsequence
  property p_crc_start; s_crc_req |=> s_alert_low; endproperty
  a_crc_start: assert property (p_crc_start)
    else $error("crc error did not pull alert low");
  property p_par_start; o_par_err |=> s_alert_low; endproperty
  a_par_start: assert property (p_par_start)
    else $error("parity error did not pull alert low");
  property p_alert_len;
    $rose(o_alert_out) |-> low_cnt_r == (par_kind_r ? REC_CYC : CRC_CYC);
  endproperty
  a_alert_len: assert property (p_alert_len)
    else $error("alert low time wrong");
  property p_par_nocmd;
    o_par_err |-> !o_cmd_valid && !o_act_valid;
  endproperty
  a_par_nocmd: assert property (p_par_nocmd)
    else $error("command passed despite parity error");
  property p_cmd_pulse;
    o_cmd_valid |-> !o_act_valid ##1 !o_cmd_valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command pulse malformed");
  property p_ct_oe; i_conn_test [*2] |-> !o_alert_oe; endproperty
  a_ct_oe: assert property (p_ct_oe)
    else $error("alert driven in connectivity test");
  property p_store_hold;
    o_store_valid && !i_store_ready |=> o_store_valid && $stable(o_store_data);
  endproperty
  a_store_hold: assert property (p_store_hold)
    else $error("stored word lost during stall");
  property p_rtt_off; !i_rtt_en [*2] |-> o_rtt_on_dq == 2'h0; endproperty
  a_rtt_off: assert property (p_rtt_off)
    else $error("termination on while disabled");
  property p_event; !i_has_sensor [*2] |-> o_event_n; endproperty
  a_event: assert property (p_event)
    else $error("event asserted without sensor");
  // Shared pin taken by the termination strobe leaves no room for inversion
  property p_rdbi;
    i_mr5[12] [*2] ##0 !o_tdqs_mode |-> o_rdbi_en;
  endproperty
  a_rdbi: assert property (p_rdbi)
    else $error("read inversion not enabled");
  property p_tail; o_crc_tail |-> i_mr2[12] ##1 !o_crc_tail; endproperty
  a_tail: assert property (p_tail)
    else $error("crc tail without crc mode");
endmodule
bind sdrpf_top sdrpf_chk #(.CRC_CYC(CRC_CYC), .REC_CYC(REC_CYC))
  sdrpf_chk_inst (.*);

// >>> tb/sdrpf_host.sv
// Host controller model driving command pins in link clock frames
`timescale 1ns/1ns
module sdrpf_host (
  output logic o_reset_n,
  output logic o_ck_t,
  output logic o_ck_c,
  output logic o_cs_n,
  output logic o_act_n,
  output logic o_ras_n_a16,
  output logic o_cas_n_a15,
  output logic o_we_n_a14,
  output logic [1:0] o_bg,
  output logic [1:0] o_ba,
  output logic [13:0] o_a_lo,
  output logic o_parity,
  output logic o_odt
);
  //////////////////////////////////////////////////////////////////////
  // Idle bus: clock parked, deselected, pin reset released
  initial begin
    {o_ck_t, o_ck_c, o_cs_n, o_reset_n, o_odt} = 5'h0E;
    {o_act_n, o_ras_n_a16, o_cas_n_a15, o_we_n_a14} = 4'hF;
    {o_bg, o_ba, o_a_lo, o_parity} = 19'h00000;
  end
  // One frame: {act,ras,cas,we,a10,a12,cs,bad parity} in e[7:0]
  task automatic cmd(input logic [8:0] e);
    o_cs_n = e[1];
    {o_act_n, o_ras_n_a16, o_cas_n_a15, o_we_n_a14} = e[7:4];
    {o_bg, o_ba} = 4'h9;
    o_a_lo = {1'h0, e[2], 1'h0, e[3], 10'h155};
    o_parity = e[0] ^ (^{e[7:4], o_bg, o_ba, o_a_lo});
    // Link edges kept off the system clock's rising edge
    #62 o_ck_t = 1'b1;
    o_ck_c = 1'b0;
    #62 o_ck_t = 1'b0;
    o_ck_c = 1'b1;
    // Released pins flip so a stale value never looks valid
    #63 o_cs_n = 1'b1;
    {o_act_n, o_ras_n_a16, o_cas_n_a15, o_we_n_a14} = ~e[7:4];
    {o_bg, o_ba, o_a_lo, o_parity} = ~{o_bg, o_ba, o_a_lo, o_parity};
  endtask
endmodule

// >>> tb/tb_sdrpf_top.sv
// Testbench for the memory-side pin block
`timescale 1ns/1ns
module tb_sdrpf_top;
  localparam int CRC = 3;
  localparam int REC = 6;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_reset_n, i_ck_t, i_ck_c, i_cs_n, i_act_n, i_ras_n_a16;
  logic i_cas_n_a15, i_we_n_a14, i_parity, i_odt;
  logic [1:0] i_bg, i_ba;
  logic [13:0] i_a_lo;
  logic i_x16 = 1'b1, i_rtt_en = 1'b0, i_conn_test = 1'b0;
  logic i_temp_crit = 1'b0, i_has_sensor = 1'b0, i_wvalid = 1'b0;
  logic i_wcrc_err = 1'b0, i_rvalid = 1'b0, i_store_ready = 1'b0;
  logic i_alert_in = 1'b1;
  logic [15:0] i_mr1 = 16'h0000, i_mr2 = 16'h0000, i_mr4 = 16'h0000;
  logic [15:0] i_mr5 = 16'h0001, i_wdata = 16'h0000, i_rdata = 16'h0000;
  logic [1:0] i_wmask_n = 2'h3, i_wdbi_n = 2'h3;
  logic [3:0] i_vref_probe = 4'h0;
  logic o_wready, o_store_valid, o_dqs_t, o_dqs_c, o_rtt_on_tdqs;
  logic o_tdqs_mode, o_dm_en, o_wdbi_en, o_rdbi_en, o_cmd_valid;
  logic o_act_valid, o_auto_pre, o_pre_all, o_burst_chop, o_crc_tail;
  logic o_par_err, o_alert_out, o_alert_oe, o_alert_seen_n, o_event_n;
  logic [15:0] o_store_data, o_dq_out, o_dq_oe;
  logic [1:0] o_store_en, o_rdbi_n, o_dqs_oe, o_rtt_on_dq, o_rtt_on_dqs;
  logic [1:0] o_rtt_on_dm, o_bg, o_ba;
  logic [2:0] o_cmd;
  logic [16:0] o_row;
  logic [13:0] o_col;
  int errors, checked, cyc, n_cmd, n_act, n_par, n_tail, lowrun, last_low;

  sdrpf_top #(.CRC_CYC(CRC), .REC_CYC(REC)) sdrpf_top_inst (.*);
  sdrpf_host sdrpf_host_inst (.o_reset_n(i_reset_n), .o_ck_t(i_ck_t),
    .o_ck_c(i_ck_c), .o_cs_n(i_cs_n), .o_act_n(i_act_n),
    .o_ras_n_a16(i_ras_n_a16), .o_cas_n_a15(i_cas_n_a15),
    .o_we_n_a14(i_we_n_a14), .o_bg(i_bg), .o_ba(i_ba), .o_a_lo(i_a_lo),
    .o_parity(i_parity), .o_odt(i_odt));

  always #5 i_clk = ~i_clk;
  //////////////////////////////////////////////////////////////////////
  // Pulse counters and alert low-run length; pulses last one cycle only
  always @(posedge i_clk) begin
    cyc++;
    if (o_cmd_valid === 1'b1) n_cmd++;
    if (o_act_valid === 1'b1) n_act++;
    if (o_par_err === 1'b1) n_par++;
    if (o_crc_tail === 1'b1) n_tail++;
    if (o_alert_out === 1'b0) lowrun++;
    else begin
      if (lowrun != 0) last_low = lowrun;
      lowrun = 0;
    end
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Entries {pin reset low, act, ras, cas, we, a10, a12, cs_n, bad par}
  task automatic t_cmd;
    logic [8:0] tbl [7] = '{9'h058, 9'h0D8, 9'h0C4, 9'h0A8, 9'h0DA,
      9'h1D8, 9'h0D9};
    logic [8:0] e;
    logic [13:0] alo;
    logic ok;
    int a0, c0, p0;
    for (int i = 0; i < 7; i++) begin
      e = tbl[i];
      sdrpf_host_inst.o_reset_n = !e[8];
      repeat (4) @(negedge i_clk);
      {a0, c0, p0} = {n_act, n_cmd, n_par};
      sdrpf_host_inst.cmd(e);
      repeat (6) @(negedge i_clk);
      ok = !e[8] && !e[1] && !e[0];
      alo = {1'h0, e[2], 1'h0, e[3], 10'h155};
      chk("act", n_act - a0, ok && !e[7]);
      chk("cmd", n_cmd - c0, ok && e[7]);
      chk("par", n_par - p0, !e[8] && !e[1] && e[0]);
      if (ok && !e[7])
        chk("row", {o_bg, o_ba, o_row}, {4'h9, e[6:4], alo});
      if (ok && e[7] && e[6:4] != 3'h2)
        chk("rw", {o_cmd, o_auto_pre, o_burst_chop, o_col},
          {e[6:4], e[3], !e[2], alo});
      if (ok && e[6:4] == 3'h2)
        chk("pre", {o_cmd, o_pre_all}, {e[6:4], e[3]});
    end
    chk("par_low", last_low, REC);
    $display("t_cmd done");
  endtask

  task automatic push(input logic [15:0] d, input logic [1:0] m, b);
    int n;
    @(negedge i_clk);
    {i_wdata, i_wmask_n, i_wdbi_n, i_wvalid} = {d, m, b, 1'b1};
    n = 0;
    while (o_wready !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    @(negedge i_clk) i_wvalid = 1'b0;
  endtask

  task automatic pop(input logic [15:0] d, input logic [1:0] en);
    int n;
    @(negedge i_clk) i_store_ready = 1'b1;
    n = 0;
    while (o_store_valid !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk("store", {o_store_data, o_store_en}, {d, en});
    @(negedge i_clk) i_store_ready = 1'b0;
  endtask

  // Receiver stalls until the buffer refuses, then drains it dry
  task automatic t_wr;
    @(negedge i_clk) i_mr5 = 16'h0400;
    repeat (3) @(negedge i_clk);
    push(16'h1357, 2'h3, 2'h3);
    push(16'hA55A, 2'h1, 2'h3);
    chk("full", o_wready, 1'b0);
    pop(16'h1357, 2'h3);
    pop(16'hA55A, 2'h1);
    chk("empty", o_store_valid, 1'b0);
    push(16'h5555, 2'h0, 2'h3);
    repeat (2) @(negedge i_clk);
    chk("masked", o_store_valid, 1'b0);
    i_mr5 = 16'h0800;
    repeat (3) @(negedge i_clk);
    chk("dbi_en", {o_dm_en, o_wdbi_en}, 2'h1);
    push(16'h1234, 2'h3, 2'h2);
    pop(16'h12CB, 2'h3);
    $display("t_wr done");
  endtask

  task automatic t_rd;
    int t0;
    @(negedge i_clk) i_mr5 = 16'h1000;
    i_mr2 = 16'h1000;
    repeat (3) @(negedge i_clk);
    t0 = n_tail;
    for (int i = 0; i < 8; i++) begin
      {i_rvalid, i_rdata} = {1'b1, 16'h8005};
      @(negedge i_clk);
      if (i == 0)
        chk("dqs", {o_dqs_t, o_dqs_c, o_dq_oe}, 18'h2FFFF);
      if (i == 1)
        chk("rd", {o_dq_out, o_rdbi_n, o_dqs_oe}, 20'h80FAB);
    end
    i_rvalid = 1'b0;
    repeat (5) @(negedge i_clk);
    chk("tail", n_tail - t0, 32'h1);
    i_wcrc_err = 1'b1;
    @(negedge i_clk) i_wcrc_err = 1'b0;
    repeat (8) @(negedge i_clk);
    chk("crc_low", last_low, CRC);
    $display("t_rd done");
  endtask

  task automatic t_pins;
    {i_conn_test, i_alert_in} = 2'h2;
    repeat (4) @(negedge i_clk);
    chk("ct", {o_alert_oe, o_alert_seen_n}, 2'h0);
    {i_conn_test, i_alert_in, i_has_sensor, i_temp_crit} = 4'h7;
    repeat (4) @(negedge i_clk);
    chk("event", o_event_n, 1'b0);
    {i_temp_crit, i_mr4, i_vref_probe} = {1'b0, 16'h0010, 4'hA};
    repeat (3) @(negedge i_clk);
    chk("vref", {o_dq_oe[3:0], o_dq_out[3:0]}, 8'hFA);
    {i_mr4, i_rtt_en} = {16'h0000, 1'b1};
    sdrpf_host_inst.o_odt = 1'b1;
    sdrpf_host_inst.cmd(9'h0DA);
    repeat (3) @(negedge i_clk);
    chk("rtt16", {o_rtt_on_dq, o_rtt_on_dqs, o_rtt_on_dm}, 6'h3F);
    {i_x16, i_mr1} = {1'b0, 16'h0800};
    sdrpf_host_inst.cmd(9'h0DA);
    repeat (3) @(negedge i_clk);
    chk("tdqs", {o_tdqs_mode, o_rtt_on_tdqs}, 2'h3);
    i_rtt_en = 1'b0;
    repeat (3) @(negedge i_clk);
    chk("rtt_off", {o_rtt_on_dq, o_rtt_on_tdqs}, 3'h0);
    $display("t_pins done");
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    @(negedge i_clk) i_sys_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    t_cmd;
    t_wr;
    t_rd;
    t_pins;
    end_of_test;
  end
endmodule
